// [pmtr_consts.svh]
// constants for the program memory and table read block
`ifndef PMTR_CONSTS_SVH
`define PMTR_CONSTS_SVH

`define PMTR_ADDR_W        12
`define PMTR_WORD_W        16
`define PMTR_BYTE_W        8
`define PMTR_MEM_DEPTH     4096
`define PMTR_PC_RESET      12'h000
`define PMTR_PAGE_HI_W     4
`define PMTR_LAST_PAGE     4'hf
`define PMTR_SECTOR0       8'h00
`define PMTR_CYC_LAST      2'h3
`define PMTR_TBL_HI_RESET  8'h00
`define PMTR_ICP_ADDR_LAST 5'h0b
`define PMTR_ICP_DATA_LAST 5'h0f
`define PMTR_ICP_DATA_CNT  5'h10

`endif

// [pmtr_pkg.sv]
// types for the program memory and table read block
`include "pmtr_consts.svh"

package pmtr_pkg;

    typedef enum logic [1:0] {TR_IDLE, TR_FETCH, TR_XFER} pmtr_tr_state_t;

    typedef enum logic [1:0] {ICP_CMD, ICP_ADDR, ICP_WDATA, ICP_RDATA} pmtr_icp_state_t;

    typedef struct packed {
        logic [1:0]                  cycDiv;
        logic                        cycEn;
        logic [`PMTR_ADDR_W-1:0]     pc;
        logic [`PMTR_WORD_W-1:0]     instr;
        logic [`PMTR_BYTE_W-1:0]     tblHigh;
        pmtr_tr_state_t              trState;
        logic [`PMTR_ADDR_W-1:0]     trAddr;
        logic [`PMTR_WORD_W-1:0]     trWord;
        logic [`PMTR_BYTE_W-1:0]     trSector;
        logic [`PMTR_BYTE_W-1:0]     trOffset;
        logic                        trBusy;
        logic                        dmWrEn;
        logic [`PMTR_BYTE_W-1:0]     dmWrSector;
        logic [`PMTR_BYTE_W-1:0]     dmWrOffset;
        logic [`PMTR_BYTE_W-1:0]     dmWrData;
        logic [1:0]                  ckSync;
        logic [1:0]                  daSync;
        logic                        ckPrev;
        pmtr_icp_state_t             icpState;
        logic                        icpWrite;
        logic [4:0]                  icpCnt;
        logic [`PMTR_ADDR_W-1:0]     icpAddr;
        logic [`PMTR_WORD_W-1:0]     icpShift;
        logic                        sdaOut;
        logic                        sdaOe;
        logic                        memWr;
        logic [`PMTR_ADDR_W-1:0]     memWrAddr;
        logic [`PMTR_WORD_W-1:0]     memWrData;
    } pmtr_state_t;

endpackage : pmtr_pkg

// [pmtr_program_memory_table_read.sv]
// program memory, program counter, table read engine and serial programming port
`include "pmtr_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pmtr_program_memory_table_read (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      pcIncr,
    input  wire logic                      pcLoad,
    input  wire logic [`PMTR_ADDR_W-1:0]   pcLoadValue,
    input  wire logic                      pclWrite,
    input  wire logic [`PMTR_BYTE_W-1:0]   pclWriteData,
    output var  logic [`PMTR_ADDR_W-1:0]   programCounter,
    output var  logic [`PMTR_BYTE_W-1:0]   programCounterLow,
    output var  logic [`PMTR_WORD_W-1:0]   instrWord,
    output var  logic                      cycleEnable,
    input  wire logic                      tableReadReq,
    input  wire logic                      tableReadExtended,
    input  wire logic                      tableReadLastPage,
    input  wire logic [`PMTR_BYTE_W-1:0]   tablePtrLow,
    input  wire logic [`PMTR_BYTE_W-1:0]   tablePtrHigh,
    input  wire logic [`PMTR_BYTE_W-1:0]   destSector,
    input  wire logic [`PMTR_BYTE_W-1:0]   destOffset,
    output var  logic                      tableReadBusy,
    output var  logic                      dmWriteEn,
    output var  logic [`PMTR_BYTE_W-1:0]   dmWriteSector,
    output var  logic [`PMTR_BYTE_W-1:0]   dmWriteOffset,
    output var  logic [`PMTR_BYTE_W-1:0]   dmWriteData,
    input  wire logic                      tblHighWrite,
    input  wire logic [`PMTR_BYTE_W-1:0]   tblHighWriteData,
    output var  logic [`PMTR_BYTE_W-1:0]   tableHighByteLatch,
    input  wire logic                      programmingEnable,
    input  wire logic                      programmingClock,
    input  wire logic                      programmingSerialDataIn,
    output var  logic                      programmingSerialDataOut,
    output var  logic                      programmingSerialDataOe
);

    ////////////////////////////////////////////////////////////////////////////
    // storage

    logic [`PMTR_WORD_W-1:0] progStore [0:`PMTR_MEM_DEPTH-1];

    pmtr_pkg::pmtr_state_t s_q;
    pmtr_pkg::pmtr_state_t s_d;

    // pointer high bits above the address width dropped
    function automatic logic [`PMTR_ADDR_W-1:0] tableAddr(
        input logic                     lastPage,
        input logic [`PMTR_BYTE_W-1:0] ptrHigh,
        input logic [`PMTR_BYTE_W-1:0] ptrLow
    );
        logic [`PMTR_PAGE_HI_W-1:0] page;
        page = lastPage ? `PMTR_LAST_PAGE : ptrHigh[`PMTR_PAGE_HI_W-1:0];
        return {page, ptrLow};
    endfunction : tableAddr

    logic ckRise;
    logic ckFall;
    logic [`PMTR_ADDR_W-1:0] icpNextAddr;

    assign ckRise      = s_q.ckSync[1] & ~s_q.ckPrev;
    assign ckFall      = ~s_q.ckSync[1] & s_q.ckPrev;
    assign icpNextAddr = {s_q.icpAddr[`PMTR_ADDR_W-2:0], s_q.daSync[1]};

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_d        = s_q;
        s_d.dmWrEn = 1'b0;
        s_d.memWr  = 1'b0;

        // instruction cycle enable, one pulse every four clocks
        s_d.cycEn  = (s_q.cycDiv == `PMTR_CYC_LAST);
        s_d.cycDiv = s_q.cycDiv + 2'h1;

        // program counter
        if (pcLoad)
        begin
            s_d.pc = pcLoadValue;
        end
        else if (pclWrite)
        begin
            s_d.pc = {s_q.pc[`PMTR_ADDR_W-1:`PMTR_BYTE_W], pclWriteData};
        end
        else if (pcIncr && s_q.cycEn)
        begin
            s_d.pc = s_q.pc + `PMTR_ADDR_W'(1);
        end
        s_d.instr = progStore[s_q.pc];

        // software access to the latch
        if (tblHighWrite)
        begin
            s_d.tblHigh = tblHighWriteData;
        end

        // table read engine
        case (s_q.trState)
            pmtr_pkg::TR_IDLE:
            begin
                if (tableReadReq)
                begin
                    s_d.trAddr   = tableAddr(tableReadLastPage, tablePtrHigh, tablePtrLow);
                    s_d.trSector = tableReadExtended ? destSector : `PMTR_SECTOR0;
                    s_d.trOffset = destOffset;
                    s_d.trBusy   = 1'b1;
                    s_d.trState  = pmtr_pkg::TR_FETCH;
                end
            end
            pmtr_pkg::TR_FETCH:
            begin
                if (s_q.cycEn)
                begin
                    s_d.trWord  = progStore[s_q.trAddr];
                    s_d.trState = pmtr_pkg::TR_XFER;
                end
            end
            pmtr_pkg::TR_XFER:
            begin
                if (s_q.cycEn)
                begin
                    s_d.dmWrEn     = 1'b1;
                    s_d.dmWrSector = s_q.trSector;
                    s_d.dmWrOffset = s_q.trOffset;
                    s_d.dmWrData   = s_q.trWord[`PMTR_BYTE_W-1:0];
                    // hardware load wins over a software write
                    s_d.tblHigh    = s_q.trWord[`PMTR_WORD_W-1:`PMTR_BYTE_W];
                    s_d.trBusy     = 1'b0;
                    s_d.trState    = pmtr_pkg::TR_IDLE;
                end
            end
            default:
            begin
                s_d.trBusy  = 1'b0;
                s_d.trState = pmtr_pkg::TR_IDLE;
            end
        endcase

        // programming pins synchronised
        s_d.ckSync = {s_q.ckSync[0], programmingClock};
        s_d.daSync = {s_q.daSync[0], programmingSerialDataIn};
        s_d.ckPrev = s_q.ckSync[1];

        // serial programming port
        if (!programmingEnable)
        begin
            s_d.icpState = pmtr_pkg::ICP_CMD;
            s_d.icpCnt   = 5'h00;
            s_d.sdaOe    = 1'b0;
            s_d.sdaOut   = 1'b0;
        end
        else
        begin
            case (s_q.icpState)
                pmtr_pkg::ICP_CMD:
                begin
                    if (ckRise)
                    begin
                        s_d.icpWrite = s_q.daSync[1];
                        s_d.icpCnt   = 5'h00;
                        s_d.icpState = pmtr_pkg::ICP_ADDR;
                    end
                end
                pmtr_pkg::ICP_ADDR:
                begin
                    if (ckRise)
                    begin
                        s_d.icpAddr = icpNextAddr;
                        s_d.icpCnt  = s_q.icpCnt + 5'h01;
                        if (s_q.icpCnt == `PMTR_ICP_ADDR_LAST)
                        begin
                            s_d.icpCnt   = 5'h00;
                            s_d.icpShift = progStore[icpNextAddr];
                            s_d.icpState = s_q.icpWrite ? pmtr_pkg::ICP_WDATA
                                                        : pmtr_pkg::ICP_RDATA;
                        end
                    end
                end
                pmtr_pkg::ICP_WDATA:
                begin
                    if (ckRise)
                    begin
                        s_d.icpShift = {s_q.icpShift[`PMTR_WORD_W-2:0], s_q.daSync[1]};
                        s_d.icpCnt   = s_q.icpCnt + 5'h01;
                        if (s_q.icpCnt == `PMTR_ICP_DATA_LAST)
                        begin
                            s_d.memWr     = 1'b1;
                            s_d.memWrAddr = s_q.icpAddr;
                            s_d.memWrData = {s_q.icpShift[`PMTR_WORD_W-2:0], s_q.daSync[1]};
                            s_d.icpState  = pmtr_pkg::ICP_CMD;
                        end
                    end
                end
                pmtr_pkg::ICP_RDATA:
                begin
                    if (ckFall)
                    begin
                        if (s_q.icpCnt == `PMTR_ICP_DATA_CNT)
                        begin
                            s_d.sdaOe    = 1'b0;
                            s_d.sdaOut   = 1'b0;
                            s_d.icpState = pmtr_pkg::ICP_CMD;
                        end
                        else
                        begin
                            s_d.sdaOe    = 1'b1;
                            s_d.sdaOut   = s_q.icpShift[`PMTR_WORD_W-1];
                            s_d.icpShift = {s_q.icpShift[`PMTR_WORD_W-2:0], 1'b0};
                            s_d.icpCnt   = s_q.icpCnt + 5'h01;
                        end
                    end
                end
                default:
                begin
                    s_d.icpState = pmtr_pkg::ICP_CMD;
                    s_d.sdaOe    = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q          <= '0;
            s_q.pc       <= `PMTR_PC_RESET;
            s_q.tblHigh  <= `PMTR_TBL_HI_RESET;
            s_q.trState  <= pmtr_pkg::TR_IDLE;
            s_q.icpState <= pmtr_pkg::ICP_CMD;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // program store written by the programming port
    always_ff @(posedge clk)
    begin
        if (s_q.memWr)
        begin
            progStore[s_q.memWrAddr] <= s_q.memWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign programCounter           = s_q.pc;
    assign programCounterLow        = s_q.pc[`PMTR_BYTE_W-1:0];
    assign instrWord                = s_q.instr;
    assign cycleEnable              = s_q.cycEn;
    assign tableReadBusy            = s_q.trBusy;
    assign dmWriteEn                = s_q.dmWrEn;
    assign dmWriteSector            = s_q.dmWrSector;
    assign dmWriteOffset            = s_q.dmWrOffset;
    assign dmWriteData              = s_q.dmWrData;
    assign tableHighByteLatch       = s_q.tblHigh;
    assign programmingSerialDataOut = s_q.sdaOut;
    assign programmingSerialDataOe  = s_q.sdaOe;

endmodule : pmtr_program_memory_table_read

`default_nettype wire

// [pmtr_checker.sv]
// assertions on the table read, latch, program counter and serial programming ports
`timescale 1ns/1ps
`default_nettype none
module pmtr_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [11:0] programCounter,
    input wire logic [7:0]  programCounterLow,
    input wire logic        tableReadReq,
    input wire logic        tableReadExtended,
    input wire logic [7:0]  destSector,
    input wire logic [7:0]  destOffset,
    input wire logic        tableReadBusy,
    input wire logic        dmWriteEn,
    input wire logic [7:0]  dmWriteSector,
    input wire logic [7:0]  dmWriteOffset,
    input wire logic        tblHighWrite,
    input wire logic [7:0]  tblHighWriteData,
    input wire logic [7:0]  tableHighByteLatch,
    input wire logic        programmingEnable,
    input wire logic        programmingSerialDataOe
);
    default clocking @(posedge clk); endclocking
    logic       extQ;
    logic [7:0] secQ;
    logic [7:0] offQ;
    // destination seen at acceptance
    always_ff @(posedge clk)
    begin
        if (tableReadReq && !tableReadBusy)
        begin
            extQ <= tableReadExtended;
            secQ <= destSector;
            offQ <= destOffset;
        end
    end
    sequence trTaken;
        tableReadReq && !tableReadBusy;
    endsequence
    sequence trDone;
        dmWriteEn && !tableReadBusy;
    endsequence
    AST_PC_RESET: assert property (!rst_n |=> programCounter == 12'h000)
        else $error("pc not zero after reset");
    AST_PCL_MIRROR: assert property (disable iff (!rst_n)
        programCounterLow == programCounter[7:0]) else $error("pc low byte differs");
    AST_TR_BUSY: assert property (disable iff (!rst_n) trTaken |=> tableReadBusy)
        else $error("busy missing after take");
    AST_TR_TIME: assert property (disable iff (!rst_n) trTaken |-> ##[6:9] trDone)
        else $error("table read too slow");
    AST_WR_BUSY: assert property (disable iff (!rst_n) dmWriteEn |-> $past(tableReadBusy))
        else $error("write pulse without read");
    AST_SECTOR: assert property (disable iff (!rst_n)
        dmWriteEn |-> dmWriteSector == (extQ ? secQ : 8'h00)) else $error("wrong sector");
    AST_OFFSET: assert property (disable iff (!rst_n)
        dmWriteEn |-> dmWriteOffset == offQ) else $error("wrong offset");
    AST_LATCH_SW: assert property (disable iff (!rst_n)
        tblHighWrite && !tableReadBusy |=> tableHighByteLatch == $past(tblHighWriteData))
        else $error("latch write lost");
    AST_OE_OFF: assert property (disable iff (!rst_n)
        !programmingEnable |=> !programmingSerialDataOe) else $error("drive while disabled");
endmodule : pmtr_checker

bind pmtr_program_memory_table_read pmtr_checker chk (
    .clk, .rst_n, .programCounter, .programCounterLow, .tableReadReq, .tableReadExtended,
    .destSector, .destOffset, .tableReadBusy, .dmWriteEn, .dmWriteSector, .dmWriteOffset,
    .tblHighWrite, .tblHighWriteData, .tableHighByteLatch, .programmingEnable,
    .programmingSerialDataOe
);
`default_nettype wire

// [pmtr_cpu_model.sv]
// core-side model issuing table read requests
`timescale 1ns/1ps
`default_nettype none
module pmtr_cpu_model (
    input  wire logic       clk,
    output var  logic       req,
    output var  logic       ext,
    output var  logic       last,
    output var  logic [7:0] ptrLow,
    output var  logic [7:0] ptrHigh,
    output var  logic [7:0] sector,
    output var  logic [7:0] offset
);
    initial {req, ext, last, ptrLow, ptrHigh, sector, offset} = '0;
    // one read at a time; poke repeats the request while busy
    task automatic table_read(input logic e, l, input logic [7:0] ph, pl, s, o,
                              input logic poke);
        @(posedge clk);
        req <= 1'b1;
        ext <= e;
        last <= l;
        ptrHigh <= ph;
        ptrLow <= pl;
        sector <= s;
        offset <= o;
        @(posedge clk);
        req <= poke;
        ptrLow <= ~pl;
        sector <= ~s;
        @(posedge clk);
        req <= 1'b0;
        repeat (10) @(posedge clk);
    endtask : table_read
endmodule : pmtr_cpu_model
`default_nettype wire

// [pmtr_program_memory_table_read_test.sv]
// self-checking bench for the program memory table read block
`timescale 1ns/1ps
`default_nettype none
module pmtr_program_memory_table_read_test;
    logic        clk = 1'b0, rst_n = 1'b0, pcIncr = 1'b0, pcLoad = 1'b0;
    logic        pclWrite = 1'b0, tblHighWrite = 1'b0;
    logic        pgmEn = 1'b0, pgmClk = 1'b0, hostSda = 1'b0;
    logic [11:0] pcLoadValue = 12'h000, programCounter;
    logic [7:0]  pclWriteData = 8'h00, tblHighWriteData = 8'h00, programCounterLow;
    logic [7:0]  tablePtrLow, tablePtrHigh, destSector, destOffset;
    logic [7:0]  dmWriteSector, dmWriteOffset, dmWriteData, tableHighByteLatch;
    logic [15:0] instrWord;
    logic        cycleEnable, tableReadReq, tableReadExtended, tableReadLastPage;
    logic        tableReadBusy, dmWriteEn, sdaOut, sdaOe;
    wire logic   sdaLine;
    int          mismatches = 0, cmp_count = 0;
    assign sdaLine = sdaOe ? sdaOut : hostSda;
    always #20 clk = ~clk;
    pmtr_program_memory_table_read dut (.clk, .rst_n, .pcIncr, .pcLoad, .pcLoadValue,
        .pclWrite, .pclWriteData, .programCounter, .programCounterLow, .instrWord,
        .cycleEnable, .tableReadReq, .tableReadExtended, .tableReadLastPage, .tablePtrLow,
        .tablePtrHigh, .destSector, .destOffset, .tableReadBusy, .dmWriteEn, .dmWriteSector,
        .dmWriteOffset, .dmWriteData, .tblHighWrite, .tblHighWriteData, .tableHighByteLatch,
        .programmingEnable(pgmEn), .programmingClock(pgmClk),
        .programmingSerialDataIn(sdaLine), .programmingSerialDataOut(sdaOut),
        .programmingSerialDataOe(sdaOe));
    pmtr_cpu_model cpu (.clk, .req(tableReadReq), .ext(tableReadExtended),
        .last(tableReadLastPage), .ptrLow(tablePtrLow), .ptrHigh(tablePtrHigh),
        .sector(destSector), .offset(destOffset));
    task automatic chk(input logic [15:0] got, exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // serial frame: command, address, then data in or out
    task automatic icp(input logic wr, input logic [11:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        logic [28:0] bits;
        bits = {wr, a, d};
        q = 16'h0000;
        for (int i = 28; i >= (wr ? 0 : 16); i--)
        begin
            hostSda <= bits[i];
            repeat (8) @(posedge clk);
            pgmClk <= 1'b1;
            repeat (8) @(posedge clk);
            pgmClk <= 1'b0;
        end
        for (int i = 0; i < (wr ? 0 : 16); i++)
        begin
            hostSda <= ~hostSda;
            repeat (8) @(posedge clk);
            pgmClk <= 1'b1;
            q = {q[14:0], sdaLine};
            repeat (8) @(posedge clk);
            pgmClk <= 1'b0;
        end
        repeat (8) @(posedge clk);
    endtask : icp
    task automatic t_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk(programCounter, 12'h000);
        chk(tableHighByteLatch, 8'h00);
        chk(cycleEnable, 1'b0);
    endtask : t_reset
    task automatic t_icp;
        logic [15:0] q;
        @(posedge clk);
        pgmEn <= 1'b1;
        icp(1'b1, 12'hf06, 16'h5a1b, q);
        icp(1'b1, 12'h305, 16'hc30f, q);
        icp(1'b0, 12'hf06, 16'h0000, q);
        chk(q, 16'h5a1b);
        icp(1'b0, 12'h305, 16'h0000, q);
        chk(q, 16'hc30f);
        @(negedge clk);
        chk(sdaOe, 1'b0);
    endtask : t_icp
    task automatic t_read(input logic e, l, poke, input logic [7:0] ph, pl,
                          input logic [15:0] w);
        cpu.table_read(e, l, ph, pl, 8'h44, 8'h21, poke);
        @(negedge clk);
        chk({tableHighByteLatch, dmWriteData}, w);
        chk({dmWriteSector, dmWriteOffset}, {e ? 8'h44 : 8'h00, 8'h21});
        chk(dmWriteEn, 1'b0);
    endtask : t_read
    task automatic t_latch;
        @(posedge clk);
        tblHighWrite <= 1'b1;
        tblHighWriteData <= 8'ha5;
        @(posedge clk);
        tblHighWrite <= 1'b0;
        @(negedge clk);
        chk(tableHighByteLatch, 8'ha5);
    endtask : t_latch
    task automatic t_pc;
        @(posedge clk);
        pcLoad <= 1'b1;
        pcLoadValue <= 12'h306;
        @(posedge clk);
        pcLoad <= 1'b0;
        pclWrite <= 1'b1;
        pclWriteData <= 8'h05;
        @(posedge clk);
        pclWrite <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(programCounter, 12'h305);
        chk(instrWord, 16'hc30f);
        @(posedge clk);
        pcIncr <= 1'b1;
        repeat (8) @(posedge clk);
        pcIncr <= 1'b0;
        @(negedge clk);
        chk(programCounter, 12'h307);
    endtask : t_pc
    initial
    begin
        t_reset();
        t_icp();
        t_read(1'b0, 1'b0, 1'b1, 8'hf3, 8'h05, 16'hc30f);
        t_read(1'b0, 1'b1, 1'b0, 8'h00, 8'h06, 16'h5a1b);
        t_latch();
        t_read(1'b1, 1'b0, 1'b0, 8'h03, 8'h05, 16'hc30f);
        t_read(1'b1, 1'b1, 1'b0, 8'h5c, 8'h06, 16'h5a1b);
        t_pc();
        t_reset();
        close_out();
    end
    // four frames of about 500 clocks dominate the run
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        close_out();
    end
endmodule : pmtr_program_memory_table_read_test
`default_nettype wire
